// [design/rtcf_consts.vh]
// constants for the reset timeout sequencer and its cause flags
`ifndef RTCF_CONSTS_VH
`define RTCF_CONSTS_VH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define RTCF_STATUS_IDX    8'h03
`define RTCF_PWRCTL_IDX    8'h8E
`define RTCF_SEQSTAT_IDX   8'h40
`define RTCF_ADDR_W        10

// ****************************************************************
// field positions
// ****************************************************************
`define RTCF_TIMEOUT_BIT   4
`define RTCF_PWRDOWN_BIT   3
`define RTCF_BROWNOUT_BIT  0
`define RTCF_POR_BIT       1
`define RTCF_OSCSPEED_BIT  3

// ****************************************************************
// reset values
// ****************************************************************
`define RTCF_TIMEOUT_RST   1'b1
`define RTCF_PWRDOWN_RST   1'b1
`define RTCF_POR_RST       1'b0
`define RTCF_BROWNOUT_RST  1'b0
`define RTCF_OSCSPEED_RST  1'b1

// ****************************************************************
// oscillator modes
// ****************************************************************
`define RTCF_MODE_W        3
`define RTCF_MODE_LOWPWR   3'h0
`define RTCF_MODE_CRYSTAL  3'h1
`define RTCF_MODE_HISPEED  3'h2
`define RTCF_MODE_EXTCLK   3'h3
`define RTCF_MODE_INTERNAL 3'h4
`define RTCF_MODE_RESOSC   3'h5

// ****************************************************************
// timing
// ****************************************************************
`define RTCF_DELAY_TIME_MS 72
`define RTCF_CLK_KHZ       25000
`define RTCF_DELAY_CYCLES  (`RTCF_DELAY_TIME_MS * `RTCF_CLK_KHZ)
`define RTCF_DELAY_W       21
`define RTCF_STARTUP_CYCLES 11'h400
`define RTCF_STARTUP_W     11

`endif

// [design/rtcf_delay_counter.v]
// one timeout stage: counts ticks up to a limit and flags completion
`timescale 1ns/1ps
`default_nettype none

module rtcf_delay_counter #(
  parameter W = 11
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         ce,
  input  wire         clear,
  input  wire         tick,
  input  wire [W-1:0] limit,
  output reg          done
);

  reg [W-1:0] count_reg;

  // clear held high keeps the stage parked at zero, so a restart
  // always runs the whole interval again
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= {W{1'b0}};
      done      <= 1'b0;
    end else if (ce) begin
      if (clear) begin
        count_reg <= {W{1'b0}};
        done      <= 1'b0;
      end else if (tick && !done) begin
        if (count_reg == limit - {{(W-1){1'b0}}, 1'b1}) begin
          done <= 1'b1;
        end else begin
          count_reg <= count_reg + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

`default_nettype wire

// [design/rtcf_reset_sequencer.v]
// reset timeout sequencer with reset-cause flags and Avalon-MM slave
// What this block does
// RL1: after power-on pulse ends, run delay timer, then oscillator start-up.
// RL2: timeouts run from power-on pulse; late pin release starts at once.
// RL3: crystal modes: 72 ms plus 1024 cycles, 1024 alone as tabled.
// RL4: rc/external modes: 72 ms on power-up (timer on) and brown-out.
// RL5: power control bit 0 is brown-out flag, cleared by brown-out.
// RL6: brown-out flag is don't-care with brown-out detection disabled.
// RL7: power-on flag bit 1 cleared on power-on only; software sets it.
// RL8: power-on reset clears power-on flag, sets timeout and power-down.
// RL9: brown-out shows as power-on flag 1 with brown-out flag 0.
// RL10: pin reset keeps flags; watchdog reset clears only timeout flag.
// RL11: pin reset in sleep: timeout 1, power-down 0; watchdog wake: both 0.
// RL12: delay timer gives fixed 72 ms; core held in reset meanwhile.
// RL13: brown-out during delay re-enters reset and restarts the delay.
// RL14: delay timer config bit 1 disables the timer, 0 enables it.
// RL15: internal reset released on clk once stages done and pin high.
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "rtcf_consts.vh"

module rtcf_reset_sequencer #(
  parameter [31:0] DELAY_CYCLES = `RTCF_DELAY_CYCLES
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire        porPulse,
  input  wire        brownoutPulse,
  input  wire        externalResetPin_n,
  input  wire        oscClkPin,
  input  wire        delayTimerConfigBit,
  input  wire        brownoutDetectConfigBit,
  input  wire [2:0]  oscMode,
  input  wire        watchdogTimeout,
  input  wire        sleepEnter,
  input  wire        wakeEvent,
  input  wire [9:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  output reg         coreReset_n,
  output reg         coreClockEnable,
  output reg         oscSpeedSelect
);

  // ****************************************************************
  // states
  // ****************************************************************
  localparam [2:0] ST_HOLD  = 3'h0;
  localparam [2:0] ST_DELAY = 3'h1;
  localparam [2:0] ST_OSTRT = 3'h2;
  localparam [2:0] ST_PINW  = 3'h3;
  localparam [2:0] ST_RUN   = 3'h4;
  localparam [2:0] ST_SLEEP = 3'h5;
  localparam [2:0] ST_WAKE  = 3'h6;

  localparam [`RTCF_DELAY_W-1:0] DELAY_LIMIT =
    DELAY_CYCLES[`RTCF_DELAY_W-1:0];
  localparam [`RTCF_STARTUP_W-1:0] STARTUP_LIMIT = `RTCF_STARTUP_CYCLES;

  localparam [9:0] ADDR_STATUS  = {`RTCF_STATUS_IDX, 2'b00};
  localparam [9:0] ADDR_PWRCTL  = {`RTCF_PWRCTL_IDX, 2'b00};
  localparam [9:0] ADDR_SEQSTAT = {`RTCF_SEQSTAT_IDX, 2'b00};

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  reg [1:0] porSync_reg;
  reg [1:0] brownSync_reg;
  reg [1:0] pinSync_reg;
  reg [1:0] oscSync_reg;
  reg       oscPrev_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      porSync_reg   <= 2'h3;
      brownSync_reg <= 2'h0;
      pinSync_reg   <= 2'h0;
      oscSync_reg   <= 2'h0;
      oscPrev_reg   <= 1'b0;
    end else if (ce) begin
      porSync_reg   <= {porSync_reg[0], porPulse};
      brownSync_reg <= {brownSync_reg[0], brownoutPulse};
      pinSync_reg   <= {pinSync_reg[0], externalResetPin_n};
      oscSync_reg   <= {oscSync_reg[0], oscClkPin};
      oscPrev_reg   <= oscSync_reg[1];
    end
  end

  wire porActive   = porSync_reg[1];
  // detector ignored when disabled, so the flag is left as it was
  wire brownActive = brownSync_reg[1] & brownoutDetectConfigBit; // RL6
  wire pinHigh     = pinSync_reg[1];
  wire oscTick     = oscSync_reg[1] & ~oscPrev_reg;

  // ****************************************************************
  // configuration decode
  // ****************************************************************
  wire crystalMode  = (oscMode == `RTCF_MODE_LOWPWR)  ||
                      (oscMode == `RTCF_MODE_CRYSTAL) ||
                      (oscMode == `RTCF_MODE_HISPEED);
  wire delayEnabled = ~delayTimerConfigBit; // RL14

  // ****************************************************************
  // timeout stages
  // ****************************************************************
  reg  [2:0] state_reg;
  reg  [2:0] state_next;
  reg        brownCause_reg;
  wire       delayDone;
  wire       ostDone;

  // delay timer runs on clk, standing in for the internal rc clock
  rtcf_delay_counter #(
    .W     (`RTCF_DELAY_W)
  ) u_delay (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .clear (state_reg != ST_DELAY),
    .tick  (1'b1),
    .limit (DELAY_LIMIT),
    .done  (delayDone)
  ); // RL12

  rtcf_delay_counter #(
    .W     (`RTCF_STARTUP_W)
  ) u_startup (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .clear ((state_reg != ST_OSTRT) && (state_reg != ST_WAKE)),
    .tick  (oscTick),
    .limit (STARTUP_LIMIT),
    .done  (ostDone)
  );

  // ****************************************************************
  // sequencer
  // ****************************************************************
  wire needDelay = brownCause_reg | delayEnabled; // RL3 RL4

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_HOLD: begin
        if (needDelay) begin
          state_next = ST_DELAY; // RL1
        end else if (crystalMode) begin
          state_next = ST_OSTRT; // RL3
        end else begin
          state_next = ST_PINW; // RL4
        end
      end
      ST_DELAY: begin
        if (delayDone) begin
          state_next = crystalMode ? ST_OSTRT : ST_PINW; // RL1 RL3 RL4
        end
      end
      ST_OSTRT: begin
        if (ostDone) begin
          state_next = ST_PINW;
        end
      end
      ST_PINW: begin
        if (pinHigh) begin
          state_next = ST_RUN; // RL2
        end
      end
      ST_RUN: begin
        if (!pinHigh || watchdogTimeout) begin
          state_next = ST_PINW;
        end else if (sleepEnter) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (!pinHigh) begin
          state_next = ST_PINW;
        end else if (wakeEvent || watchdogTimeout) begin
          // wake-up waits for the oscillator only in crystal modes
          state_next = crystalMode ? ST_WAKE : ST_RUN; // RL3 RL4
        end
      end
      ST_WAKE: begin
        if (!pinHigh) begin
          state_next = ST_PINW;
        end else if (ostDone) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_HOLD;
      end
    endcase
    // detector pulses override every state and restart the timers
    if (porActive || brownActive) begin
      state_next = ST_HOLD; // RL13
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg      <= ST_HOLD;
      brownCause_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      if (porActive) begin
        brownCause_reg <= 1'b0;
      end else if (brownActive) begin
        brownCause_reg <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // outputs to the core
  // ****************************************************************
  // release only on a clk edge, never straight from a pin
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      coreReset_n     <= 1'b0;
      coreClockEnable <= 1'b0;
    end else if (ce) begin
      coreReset_n     <= (state_next == ST_RUN) ||
                         (state_next == ST_SLEEP) ||
                         (state_next == ST_WAKE); // RL15
      coreClockEnable <= (state_next == ST_RUN); // RL12
    end
  end

  // ****************************************************************
  // cause flags
  // ****************************************************************
  reg timeoutFlag_reg;
  reg powerDownFlag_reg;
  reg porFlag_reg;
  reg brownoutFlag_reg;
  reg oscSpeedFlag_reg;

  wire inSleep  = (state_reg == ST_SLEEP) || (state_reg == ST_WAKE);
  wire inRun    = (state_reg == ST_RUN);
  wire busWrite = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire wrPwrCtl = busWrite && (avs_address == ADDR_PWRCTL);

  // software write first, hardware event after it so the event wins
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timeoutFlag_reg   <= `RTCF_TIMEOUT_RST;
      powerDownFlag_reg <= `RTCF_PWRDOWN_RST;
      porFlag_reg       <= `RTCF_POR_RST;
      brownoutFlag_reg  <= `RTCF_BROWNOUT_RST;
      oscSpeedFlag_reg  <= `RTCF_OSCSPEED_RST;
    end else if (ce) begin
      if (wrPwrCtl) begin
        porFlag_reg      <= avs_writedata[`RTCF_POR_BIT]; // RL7
        brownoutFlag_reg <= avs_writedata[`RTCF_BROWNOUT_BIT]; // RL5
        oscSpeedFlag_reg <= avs_writedata[`RTCF_OSCSPEED_BIT];
      end
      if (porActive) begin
        porFlag_reg       <= 1'b0; // RL7 RL8
        timeoutFlag_reg   <= 1'b1; // RL8
        powerDownFlag_reg <= 1'b1; // RL8
        oscSpeedFlag_reg  <= `RTCF_OSCSPEED_RST;
      end else if (brownActive) begin
        // power-on flag untouched, so it reads 1 once software set it
        brownoutFlag_reg <= 1'b0; // RL5 RL9
        oscSpeedFlag_reg <= `RTCF_OSCSPEED_RST;
      end else if (inSleep && !pinHigh) begin
        timeoutFlag_reg   <= 1'b1; // RL11
        powerDownFlag_reg <= 1'b0; // RL11
      end else if (inSleep && watchdogTimeout) begin
        timeoutFlag_reg   <= 1'b0; // RL11
        powerDownFlag_reg <= 1'b0; // RL11
      end else if (inRun && watchdogTimeout && pinHigh) begin
        timeoutFlag_reg <= 1'b0; // RL10
      end else if (inRun && sleepEnter && pinHigh) begin
        timeoutFlag_reg   <= 1'b1;
        powerDownFlag_reg <= 1'b0;
      end
      // pin reset in normal operation leaves every flag alone (RL10)
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oscSpeedSelect <= `RTCF_OSCSPEED_RST;
    end else if (ce) begin
      oscSpeedSelect <= oscSpeedFlag_reg;
    end
  end

  // ****************************************************************
  // Avalon-MM slave
  // ****************************************************************
  reg [7:0] readValue;

  always @* begin
    readValue = 8'h00;
    case (avs_address)
      ADDR_STATUS: begin
        readValue[`RTCF_TIMEOUT_BIT] = timeoutFlag_reg;
        readValue[`RTCF_PWRDOWN_BIT] = powerDownFlag_reg;
      end
      ADDR_PWRCTL: begin
        readValue[`RTCF_OSCSPEED_BIT] = oscSpeedFlag_reg;
        readValue[`RTCF_POR_BIT]      = porFlag_reg;
        readValue[`RTCF_BROWNOUT_BIT] = brownoutFlag_reg;
      end
      ADDR_SEQSTAT: begin
        readValue = {4'h0, brownCause_reg, state_reg};
      end
      default: begin
        readValue = 8'h00;
      end
    endcase
  end

  // one wait cycle: the answer stands at the edge after the request
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else if (ce) begin
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= {24'h000000, readValue};
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// [test/rtcf_seq_assertions.sv]
// port checker for the reset timeout sequencer
`timescale 1ns/1ps
`default_nettype none
module rtcf_seq_checker #(
  parameter [31:0] DELAY_CYCLES = 32'h32
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        porPulse,
  input wire logic        brownoutPulse,
  input wire logic        externalResetPin_n,
  input wire logic        delayTimerConfigBit,
  input wire logic        brownoutDetectConfigBit,
  input wire logic        watchdogTimeout,
  input wire logic        sleepEnter,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        coreReset_n,
  input wire logic        coreClockEnable
);
  logic [31:0] sincePor_reg;
  // saturates at full scale so it never wraps
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sincePor_reg <= 32'h0;
    end else if (porPulse) begin
      sincePor_reg <= 32'h0;
    end else if (sincePor_reg != 32'hFFFF_FFFF) begin
      sincePor_reg <= sincePor_reg + 32'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_bus_onewait: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus wait bad");
  a_rd_upper: assert property (!avs_waitrequest
    |-> avs_readdata[31:8] == 24'h0) else $error("upper data set");
  a_por_hold: assert property (
    porPulse [*4] |-> !coreReset_n) else $error("no reset on power-on");
  a_bod_hold: assert property (
    (brownoutPulse && brownoutDetectConfigBit) [*4] |-> !coreReset_n)
    else $error("no reset on brown-out");
  a_pin_hold: assert property (
    !externalResetPin_n [*5] |-> !coreReset_n) else $error("pin ignored");
  a_pin_release: assert property (
    $rose(coreReset_n) |-> $past(externalResetPin_n, 3))
    else $error("released with pin low");
  a_delay_kept: assert property (
    $rose(coreReset_n) && !delayTimerConfigBit
    |-> sincePor_reg > DELAY_CYCLES) else $error("delay cut short");
  a_dog_reset: assert property (
    watchdogTimeout && coreClockEnable |-> ##[1:3] !coreReset_n)
    else $error("watchdog gave no reset");
  a_sleep_gate: assert property (
    sleepEnter && coreClockEnable |-> ##[1:2] !coreClockEnable)
    else $error("clock not gated in sleep");
  a_run_reset: assert property (
    coreClockEnable |-> coreReset_n) else $error("run while in reset");
  c_release: cover property ($rose(coreReset_n));
  c_sleep: cover property (sleepEnter && coreClockEnable);
  c_write: cover property (!avs_waitrequest && avs_write);
endmodule
bind rtcf_reset_sequencer rtcf_seq_checker #(
  .DELAY_CYCLES(DELAY_CYCLES)
) rtcf_seq_checker_i (
  .clk(clk), .rst_n(rst_n), .porPulse(porPulse),
  .brownoutPulse(brownoutPulse), .externalResetPin_n(externalResetPin_n),
  .delayTimerConfigBit(delayTimerConfigBit),
  .brownoutDetectConfigBit(brownoutDetectConfigBit),
  .watchdogTimeout(watchdogTimeout), .sleepEnter(sleepEnter),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .coreReset_n(coreReset_n),
  .coreClockEnable(coreClockEnable)
);
`default_nettype wire

// [test/rtcf_reset_sequencer_tb.sv]
// self-checking bench for the reset timeout sequencer
`timescale 1ns/1ps
`default_nettype none
module rtcf_reset_sequencer_tb;
  localparam int D = 50;
  localparam int OSC = 4096;
  localparam logic [9:0] ASTAT = 10'h00C;
  localparam logic [9:0] APWR = 10'h238;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        porPulse = 1'b1;
  logic        brownoutPulse = 1'b0;
  logic        externalResetPin_n = 1'b1;
  logic        oscClkPin = 1'b0;
  logic        delayTimerConfigBit = 1'b0;
  logic        brownoutDetectConfigBit = 1'b1;
  logic [2:0]  oscMode = 3'h1;
  logic        watchdogTimeout = 1'b0;
  logic        sleepEnter = 1'b0;
  logic [9:0]  avs_address = 10'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        coreReset_n;
  logic        coreClockEnable;
  logic        oscSpeedSelect;
  logic        ce = 1'b1;
  logic        wakeEvent = 1'b0;
  logic [1:0]  oscDiv = 2'h0;
  int          err_total = 0;
  int          checked = 0;
  rtcf_reset_sequencer #(.DELAY_CYCLES(D)) rtcf_reset_sequencer_i (
    .clk(clk), .rst_n(rst_n), .ce(ce), .porPulse(porPulse),
    .brownoutPulse(brownoutPulse), .externalResetPin_n(externalResetPin_n),
    .oscClkPin(oscClkPin), .delayTimerConfigBit(delayTimerConfigBit),
    .brownoutDetectConfigBit(brownoutDetectConfigBit), .oscMode(oscMode),
    .watchdogTimeout(watchdogTimeout), .sleepEnter(sleepEnter),
    .wakeEvent(wakeEvent), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .coreReset_n(coreReset_n),
    .coreClockEnable(coreClockEnable), .oscSpeedSelect(oscSpeedSelect)
  );
  initial begin
    forever #20 clk = ~clk;
  end
  // oscillator at a quarter of clk: each phase spans two clk edges
  always @(posedge clk) begin
    oscDiv <= oscDiv + 2'h1;
    oscClkPin <= oscDiv[1];
  end
  // ****
  // helpers
  // ****
  task automatic tally_and_finish;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input bit wr, input logic [9:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      err_total++;
      tally_and_finish();
    end
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    check(q, e);
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  // sel 0 waits on core reset release, sel 1 on the core clock enable
  task automatic wait_hi(input bit sel, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((sel ? coreClockEnable : coreReset_n) !== 1'b1 && n < 20000);
    if (n >= 20000) begin
      err_total++;
      tally_and_finish();
    end
  endtask
  task automatic span(input int n, input int lo, input int hi);
    check({31'h0, n >= lo && n <= hi}, 32'h1);
  endtask
  task automatic por_drop(input logic [2:0] m, input logic c);
    @(posedge clk);
    oscMode <= m;
    delayTimerConfigBit <= c;
    porPulse <= 1'b1;
    repeat (3) @(posedge clk);
    porPulse <= 1'b0;
  endtask
  task automatic pulse_dog;
    @(posedge clk);
    watchdogTimeout <= 1'b1;
    @(posedge clk);
    watchdogTimeout <= 1'b0;
  endtask
  task automatic pin_hit;
    @(posedge clk);
    externalResetPin_n <= 1'b0;
    repeat (6) @(posedge clk);
    externalResetPin_n <= 1'b1;
  endtask
  task automatic nap;
    @(posedge clk);
    sleepEnter <= 1'b1;
    @(posedge clk);
    sleepEnter <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_modes;
    int n;
    int e;
    for (int m = 0; m < 6; m++) begin
      for (int c = 0; c < 2; c++) begin
        e = (c ? 0 : D) + (m < 3 ? OSC : 0);
        por_drop(m[2:0], c[0]);
        wait_hi(1'b0, n);
        span(n, (e > 8) ? e - 8 : 0, e + 30);
      end
    end
  endtask
  task automatic t_pin;
    int n;
    @(posedge clk);
    externalResetPin_n <= 1'b0;
    por_drop(3'h5, 1'b0);
    repeat (D + 40) @(posedge clk);
    check(coreReset_n, 32'h0);
    externalResetPin_n <= 1'b1;
    wait_hi(1'b0, n);
    span(n, 1, 6);
    rd(ASTAT, 8'h18);
    rd(APWR, 8'h08);
  endtask
  task automatic t_regs;
    wr(APWR, 8'h03);
    // speed select follows the flag one cycle after the write lands
    repeat (2) @(posedge clk);
    check(oscSpeedSelect, 32'h0);
    rd(APWR, 8'h03);
    wr(APWR, 8'h0B);
    rd(APWR, 8'h0B);
    check(oscSpeedSelect, 32'h1);
    wr(ASTAT, 8'h00);
    rd(ASTAT, 8'h18);
    rd(10'h3FC, 8'h00);
  endtask
  task automatic t_dog_pin;
    int n;
    pulse_dog();
    wait_hi(1'b0, n);
    rd(ASTAT, 8'h08);
    pin_hit();
    wait_hi(1'b0, n);
    rd(ASTAT, 8'h08);
    rd(APWR, 8'h0B);
  endtask
  task automatic t_sleep;
    int n;
    oscMode <= 3'h1;
    nap();
    check(coreClockEnable, 32'h0);
    pin_hit();
    wait_hi(1'b1, n);
    rd(ASTAT, 8'h10);
    nap();
    pulse_dog();
    wait_hi(1'b1, n);
    span(n, OSC - 8, OSC + 30);
    rd(ASTAT, 8'h00);
    // plain wake in a non-crystal mode: no start-up wait at all
    oscMode <= 3'h5;
    nap();
    @(posedge clk);
    wakeEvent <= 1'b1;
    @(posedge clk);
    wakeEvent <= 1'b0;
    wait_hi(1'b1, n);
    span(n, 1, 6);
    rd(ASTAT, 8'h10);
    oscMode <= 3'h1;
  endtask
  task automatic t_brownout;
    int n;
    @(posedge clk);
    brownoutDetectConfigBit <= 1'b0;
    brownoutPulse <= 1'b1;
    repeat (6) @(posedge clk);
    check(coreReset_n, 32'h1);
    brownoutDetectConfigBit <= 1'b1;
    delayTimerConfigBit <= 1'b1;
    repeat (4) @(posedge clk);
    brownoutPulse <= 1'b0;
    repeat (20) @(posedge clk);
    brownoutPulse <= 1'b1;
    repeat (4) @(posedge clk);
    brownoutPulse <= 1'b0;
    // frozen cycles must not advance the timers, so the span stays put
    ce <= 1'b0;
    repeat (100) @(posedge clk);
    ce <= 1'b1;
    wait_hi(1'b0, n);
    span(n, D + OSC - 8, D + OSC + 30);
    rd(APWR, 8'h0A);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_modes();
    t_pin();
    t_regs();
    t_dog_pin();
    t_sleep();
    t_brownout();
    tally_and_finish();
  end
endmodule
`default_nettype wire
